// ==== cvp_top.sv ====
// Cell voltage protection: threshold registers on APB, per-scan comparison, qualified flags.
// Assumes one cell code per valid sample, last marks the final cell of a scan; APB slave with two wait states.
// Operation
// - Thresholds are 12-bit codes compared directly with each cell code.
// - Lockout high when any cell exceeds lockout high threshold, default e80.
// - Lockout low when any cell is below lockout low threshold, default 600.
// - Lockouts clear only when all cells meet their recovery thresholds.
// - Lockout high needs five consecutive scans above the limit.
// - Lockout low needs five consecutive scans below the limit.
// - Over condition when any cell exceeds over threshold, default e2a.
// - Over condition releases when all cells below over recovery, default dd5.
// - One timer, default 201, qualifies over detection and release.
// - Under condition when any cell below under threshold, default 900.
// - Under condition releases when all cells above under recovery, default a00.
// - Under detection qualified by programmable timer, default 201.
// - Under release waits the under timer plus three seconds.
// - Sleep level when any cell below sleep threshold, default 6aa.
// - Sleep level must persist for programmable time, default 201.
// - Precharge whenever any cell is below precharge threshold, default 7aa.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "cvp_map.svh"

module cvp_top
    import cvp_pkg::*;
#(
    parameter int MS_CYCLES = `CVP_MS_CYCLES
)
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire cvp_sample_t sample_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output cvp_flags_t       flags_out
);
    function automatic logic [8:0] tmr_count(input logic [10:0] w);
        tmr_count = w[`CVP_TMR_CNT_MSB:0];
    endfunction

    function automatic logic tmr_is_s(input logic [10:0] w);
        tmr_is_s = (w[`CVP_TMR_UNIT_MSB:`CVP_TMR_UNIT_LSB] != 2'b00);
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a[1:0] == 2'b00) && (a <= `CVP_OFF_STATUS);
    endfunction

    // Configuration registers
    logic [11:0] lock_hi_q;
    logic [11:0] lock_lo_q;
    logic [11:0] over_q;
    logic [11:0] over_rec_q;
    logic [10:0] over_tmr_q;
    logic [11:0] under_q;
    logic [11:0] under_rec_q;
    logic [10:0] under_tmr_q;
    logic [11:0] sleep_q;
    logic [10:0] sleep_tmr_q;
    logic [11:0] prechg_q;

    // APB handshake
    cvp_apb_t    apb_q;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] rd_data;

    always_comb
    begin
        wr_fire = pready_out && psel_in && penable_in && pwrite_in && addr_known(paddr_in);
        rd_fire = (apb_q == CVP_SETUP) && psel_in && penable_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            apb_q <= CVP_IDLE;
        end
        else
        begin
            unique case (apb_q)
                CVP_IDLE:  apb_q <= (psel_in && penable_in) ? CVP_SETUP : CVP_IDLE;
                CVP_SETUP: apb_q <= CVP_DONE;
                CVP_DONE:  apb_q <= CVP_IDLE;
                default:   apb_q <= CVP_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end
        else
        begin
            pready_out  <= rd_fire;
            pslverr_out <= rd_fire && !addr_known(paddr_in);
            if (rd_fire && !pwrite_in)
            begin
                prdata_out <= rd_data;
            end
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        unique case (paddr_in)
            `CVP_OFF_LOCK_HI:   rd_data = {20'h00000, lock_hi_q};
            `CVP_OFF_LOCK_LO:   rd_data = {20'h00000, lock_lo_q};
            `CVP_OFF_OVER:      rd_data = {20'h00000, over_q};
            `CVP_OFF_OVER_REC:  rd_data = {20'h00000, over_rec_q};
            `CVP_OFF_OVER_TMR:  rd_data = {21'h000000, over_tmr_q};
            `CVP_OFF_UNDER:     rd_data = {20'h00000, under_q};
            `CVP_OFF_UNDER_REC: rd_data = {20'h00000, under_rec_q};
            `CVP_OFF_UNDER_TMR: rd_data = {21'h000000, under_tmr_q};
            `CVP_OFF_SLEEP:     rd_data = {20'h00000, sleep_q};
            `CVP_OFF_SLEEP_TMR: rd_data = {21'h000000, sleep_tmr_q};
            `CVP_OFF_PRECHG:    rd_data = {20'h00000, prechg_q};
            `CVP_OFF_STATUS:    rd_data = {26'h0000000, flags_out};
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lock_hi_q   <= `CVP_RST_LOCK_HI;
            lock_lo_q   <= `CVP_RST_LOCK_LO;
            over_q      <= `CVP_RST_OVER;
            over_rec_q  <= `CVP_RST_OVER_REC;
            over_tmr_q  <= `CVP_RST_TMR;
            under_q     <= `CVP_RST_UNDER;
            under_rec_q <= `CVP_RST_UNDER_REC;
            under_tmr_q <= `CVP_RST_TMR;
            sleep_q     <= `CVP_RST_SLEEP;
            sleep_tmr_q <= `CVP_RST_TMR;
            prechg_q    <= `CVP_RST_PRECHG;
        end
        else if (wr_fire)
        begin
            unique case (paddr_in)
                `CVP_OFF_LOCK_HI:   lock_hi_q   <= pwdata_in[11:0];
                `CVP_OFF_LOCK_LO:   lock_lo_q   <= pwdata_in[11:0];
                `CVP_OFF_OVER:      over_q      <= pwdata_in[11:0];
                `CVP_OFF_OVER_REC:  over_rec_q  <= pwdata_in[11:0];
                `CVP_OFF_OVER_TMR:  over_tmr_q  <= pwdata_in[10:0];
                `CVP_OFF_UNDER:     under_q     <= pwdata_in[11:0];
                `CVP_OFF_UNDER_REC: under_rec_q <= pwdata_in[11:0];
                `CVP_OFF_UNDER_TMR: under_tmr_q <= pwdata_in[10:0];
                `CVP_OFF_SLEEP:     sleep_q     <= pwdata_in[11:0];
                `CVP_OFF_SLEEP_TMR: sleep_tmr_q <= pwdata_in[10:0];
                `CVP_OFF_PRECHG:    prechg_q    <= pwdata_in[11:0];
                default:            lock_hi_q   <= lock_hi_q;
            endcase
        end
    end

    // Per-sample comparisons, codes compared directly
    logic [12:0] prechg_rel;
    logic        s_lock_hi;
    logic        s_lock_lo;
    logic        s_over;
    logic        s_over_nrec;
    logic        s_under;
    logic        s_under_nrec;
    logic        s_sleep;
    logic        s_prechg;
    logic        s_prechg_nrel;

    always_comb
    begin
        prechg_rel    = {1'b0, prechg_q} + {1'b0, `CVP_PRECHG_HYST};
        s_lock_hi     = sample_in.code > lock_hi_q;
        s_lock_lo     = sample_in.code < lock_lo_q;
        s_over        = sample_in.code > over_q;
        s_over_nrec   = sample_in.code >= over_rec_q;
        s_under       = sample_in.code < under_q;
        s_under_nrec  = sample_in.code <= under_rec_q;
        s_sleep       = sample_in.code < sleep_q;
        s_prechg      = sample_in.code < prechg_q;
        s_prechg_nrel = {1'b0, sample_in.code} <= prechg_rel;
    end

    // Scan accumulators: any-cell flags gathered until the last sample
    logic [8:0] acc_q;
    logic [8:0] acc_now;
    logic [8:0] scan_q;

    always_comb
    begin
        acc_now = acc_q | {s_lock_hi, s_lock_lo, s_over, s_over_nrec, s_under,
                           s_under_nrec, s_sleep, s_prechg, s_prechg_nrel};
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            acc_q  <= 9'h000;
            scan_q <= 9'h000;
        end
        else if (sample_in.valid)
        begin
            acc_q <= sample_in.last ? 9'h000 : acc_now;
            if (sample_in.last)
            begin
                scan_q <= acc_now;
            end
        end
    end

    logic scan_done;
    logic any_lock_hi;
    logic any_lock_lo;

    always_comb
    begin
        scan_done   = sample_in.valid && sample_in.last;
        any_lock_hi = acc_now[8];
        any_lock_lo = acc_now[7];
    end

    // Lockouts count consecutive scans
    logic [2:0] hi_cnt_q;
    logic [2:0] lo_cnt_q;
    logic       lock_hi_flag_q;
    logic       lock_lo_flag_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            hi_cnt_q       <= 3'h0;
            lock_hi_flag_q <= 1'b0;
        end
        else if (scan_done)
        begin
            hi_cnt_q <= any_lock_hi ? ((hi_cnt_q == `CVP_LOCK_SAMPLES) ? hi_cnt_q : hi_cnt_q + 3'h1) : 3'h0;
            if (any_lock_hi && (hi_cnt_q + 3'h1 >= `CVP_LOCK_SAMPLES))
            begin
                lock_hi_flag_q <= 1'b1;
            end
            else if (!acc_now[5])
            begin
                lock_hi_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lo_cnt_q       <= 3'h0;
            lock_lo_flag_q <= 1'b0;
        end
        else if (scan_done)
        begin
            lo_cnt_q <= any_lock_lo ? ((lo_cnt_q == `CVP_LOCK_SAMPLES) ? lo_cnt_q : lo_cnt_q + 3'h1) : 3'h0;
            if (any_lock_lo && (lo_cnt_q + 3'h1 >= `CVP_LOCK_SAMPLES))
            begin
                lock_lo_flag_q <= 1'b1;
            end
            else if (!acc_now[3])
            begin
                lock_lo_flag_q <= 1'b0;
            end
        end
    end

    // Timed conditions
    logic tick_ms;
    logic tick_s;
    logic over_flag;
    logic under_flag;
    logic sleep_flag;
    logic prechg_q_flag;

    cvp_tick_gen #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .tick_ms_out (tick_ms),
        .tick_s_out  (tick_s)
    );

    cvp_qualifier u_over (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .tick_ms_in    (tick_ms),
        .tick_s_in     (tick_s),
        .detect_in     (scan_q[6]),
        .release_in    (!scan_q[5]),
        .det_count_in  (tmr_count(over_tmr_q)),
        .det_unit_s_in (tmr_is_s(over_tmr_q)),
        .rel_count_in  (tmr_count(over_tmr_q)),
        .rel_unit_s_in (tmr_is_s(over_tmr_q)),
        .rel_extra_in  (1'b0),
        .flag_out      (over_flag)
    );

    cvp_qualifier u_under (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .tick_ms_in    (tick_ms),
        .tick_s_in     (tick_s),
        .detect_in     (scan_q[4]),
        .release_in    (!scan_q[3]),
        .det_count_in  (tmr_count(under_tmr_q)),
        .det_unit_s_in (tmr_is_s(under_tmr_q)),
        .rel_count_in  (tmr_count(under_tmr_q)),
        .rel_unit_s_in (tmr_is_s(under_tmr_q)),
        .rel_extra_in  (1'b1),
        .flag_out      (under_flag)
    );

    // Sleep releases as soon as no cell is below the level
    cvp_qualifier u_sleep (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .tick_ms_in    (tick_ms),
        .tick_s_in     (tick_s),
        .detect_in     (scan_q[2]),
        .release_in    (!scan_q[2]),
        .det_count_in  (tmr_count(sleep_tmr_q)),
        .det_unit_s_in (tmr_is_s(sleep_tmr_q)),
        .rel_count_in  (9'h000),
        .rel_unit_s_in (1'b0),
        .rel_extra_in  (1'b0),
        .flag_out      (sleep_flag)
    );

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prechg_q_flag <= 1'b0;
        end
        else if (scan_done)
        begin
            if (acc_now[1])
            begin
                prechg_q_flag <= 1'b1;
            end
            else if (!acc_now[0])
            begin
                prechg_q_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            flags_out <= '0;
        end
        else
        begin
            flags_out.lockout_high    <= lock_hi_flag_q;
            flags_out.lockout_low     <= lock_lo_flag_q;
            flags_out.over_condition  <= over_flag;
            flags_out.under_condition <= under_flag;
            flags_out.sleep_level     <= sleep_flag;
            flags_out.precharge_level <= prechg_q_flag;
        end
    end

    a_lock_hi_five: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(lock_hi_flag_q) |-> $past(hi_cnt_q) >= 3'h4)
        else $error("high lockout set before five scans");

    a_lock_lo_five: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(lock_lo_flag_q) |-> $past(lo_cnt_q) >= 3'h4)
        else $error("low lockout set before five scans");

    a_lock_hi_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(lock_hi_flag_q) |-> $past(scan_done) && !$past(acc_now[5]))
        else $error("high lockout cleared without recovery");

    a_lock_lo_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(lock_lo_flag_q) |-> $past(scan_done) && !$past(acc_now[3]))
        else $error("low lockout cleared without recovery");

    a_over_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(over_flag) |-> $past(scan_q[6]))
        else $error("over condition without a high cell");

    a_under_release: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(under_flag) |-> !$past(scan_q[3]))
        else $error("under released while a cell is low");

    a_prechg_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        scan_done && acc_now[1] |=> prechg_q_flag)
        else $error("precharge not entered");

    a_prechg_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        scan_done && acc_now[0] && prechg_q_flag |=> prechg_q_flag)
        else $error("precharge left inside hysteresis");

    a_apb_ready: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        rd_fire |=> pready_out ##1 !pready_out)
        else $error("ready not a single pulse");

    a_flag_out_lag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        flags_out.lockout_high == $past(lock_hi_flag_q))
        else $error("lockout output does not follow its flag");
endmodule // cvp_top

// ==== cvp_map.svh ====
// Offsets, reset values, field positions and timing constants of the cell voltage protection block.
// Included by the package and by every design module; definitions only.
`ifndef CVP_MAP_SVH
`define CVP_MAP_SVH

// Register byte offsets on APB
`define CVP_OFF_LOCK_HI       8'h00
`define CVP_OFF_LOCK_LO       8'h04
`define CVP_OFF_OVER          8'h08
`define CVP_OFF_OVER_REC      8'h0c
`define CVP_OFF_OVER_TMR      8'h10
`define CVP_OFF_UNDER         8'h14
`define CVP_OFF_UNDER_REC     8'h18
`define CVP_OFF_UNDER_TMR     8'h1c
`define CVP_OFF_SLEEP         8'h20
`define CVP_OFF_SLEEP_TMR     8'h24
`define CVP_OFF_PRECHG        8'h28
`define CVP_OFF_STATUS        8'h2c

// Reset values
`define CVP_RST_LOCK_HI       12'he80
`define CVP_RST_LOCK_LO       12'h600
`define CVP_RST_OVER          12'he2a
`define CVP_RST_OVER_REC      12'hdd5
`define CVP_RST_TMR           11'h201
`define CVP_RST_UNDER         12'h900
`define CVP_RST_UNDER_REC     12'ha00
`define CVP_RST_SLEEP         12'h6aa
`define CVP_RST_PRECHG        12'h7aa

// Timer word layout: count in [8:0], unit in [10:9] (0 = ms, else s)
`define CVP_TMR_CNT_MSB       8
`define CVP_TMR_UNIT_MSB      10
`define CVP_TMR_UNIT_LSB      9

// Fixed figures
`define CVP_LOCK_SAMPLES      3'h5
`define CVP_PRECHG_HYST       12'h064
`define CVP_REL_EXTRA_S       13'h0003
`define CVP_MS_PER_S          13'h03e8
`define CVP_MS_NS             1000000
`define CVP_CLK_NS            50
`define CVP_MS_CYCLES         (`CVP_MS_NS / `CVP_CLK_NS)

`endif

// ==== cvp_pkg.sv ====
// Types shared by the cell voltage protection modules.
// Assumes cvp_map.svh on the include path.
`include "cvp_map.svh"

package cvp_pkg;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [11:0] code;
    } cvp_sample_t;

    typedef struct packed {
        logic lockout_high;
        logic lockout_low;
        logic over_condition;
        logic under_condition;
        logic sleep_level;
        logic precharge_level;
    } cvp_flags_t;

    typedef enum logic [1:0] {
        CVP_IDLE  = 2'b00,
        CVP_SETUP = 2'b01,
        CVP_DONE  = 2'b11
    } cvp_apb_t;

endpackage

// ==== cvp_tick_gen.sv ====
// Millisecond and second tick pulses from the system clock.
// Assumes one clock; MS_CYCLES is the clock count per millisecond.
`timescale 1ns/1ps
`include "cvp_map.svh"

module cvp_tick_gen
    import cvp_pkg::*;
#(
    parameter int MS_CYCLES = `CVP_MS_CYCLES
)
(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    output logic      tick_ms_out,
    output logic      tick_s_out
);
    logic [15:0] div_q;
    logic [12:0] ms_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_q       <= 16'h0000;
            ms_q        <= 13'h0000;
            tick_ms_out <= 1'b0;
            tick_s_out  <= 1'b0;
        end
        else
        begin
            tick_ms_out <= 1'b0;
            tick_s_out  <= 1'b0;
            if (div_q == 16'(MS_CYCLES - 1))
            begin
                div_q       <= 16'h0000;
                tick_ms_out <= 1'b1;
                if (ms_q == `CVP_MS_PER_S - 13'h0001)
                begin
                    ms_q       <= 13'h0000;
                    tick_s_out <= 1'b1;
                end
                else
                begin
                    ms_q <= ms_q + 13'h0001;
                end
            end
            else
            begin
                div_q <= div_q + 16'h0001;
            end
        end
    end
endmodule // cvp_tick_gen

// ==== cvp_qualifier.sv ====
// Holds a condition flag that sets after detection persists and clears after release persists.
// Assumes level inputs refreshed once per scan and tick pulses from cvp_tick_gen.
`timescale 1ns/1ps
`include "cvp_map.svh"

module cvp_qualifier
    import cvp_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        tick_ms_in,
    input  wire logic        tick_s_in,
    input  wire logic        detect_in,
    input  wire logic        release_in,
    input  wire logic [8:0]  det_count_in,
    input  wire logic        det_unit_s_in,
    input  wire logic [8:0]  rel_count_in,
    input  wire logic        rel_unit_s_in,
    input  wire logic        rel_extra_in,
    output logic             flag_out
);
    logic [12:0] cnt_q;
    logic [12:0] target;
    logic        unit_s;
    logic        active;
    logic        tick;

    always_comb
    begin
        unit_s = flag_out ? rel_unit_s_in : det_unit_s_in;
        active = flag_out ? release_in : detect_in;
        tick   = unit_s ? tick_s_in : tick_ms_in;
        target = {4'h0, flag_out ? rel_count_in : det_count_in};
        // Release may carry a fixed extra time in the chosen unit
        if (flag_out && rel_extra_in)
        begin
            target = target + (unit_s ? `CVP_REL_EXTRA_S : 13'(`CVP_REL_EXTRA_S * `CVP_MS_PER_S));
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q    <= 13'h0000;
            flag_out <= 1'b0;
        end
        else if (!active)
        begin
            cnt_q <= 13'h0000;
        end
        else if (cnt_q >= target)
        begin
            cnt_q    <= 13'h0000;
            flag_out <= !flag_out;
        end
        else if (tick)
        begin
            cnt_q <= cnt_q + 13'h0001;
        end
    end

    a_flag_needs_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (flag_out != $past(flag_out)) |-> $past(active))
        else $error("flag toggled without a persisting cause");
endmodule // cvp_qualifier

// ==== cvp_top_tb.sv ====
// Self-checking bench for cvp_top: register defaults and access over APB, lockouts, timed flags, precharge.
// Assumes cvp_pkg and cvp_map.svh compiled first; MS_CYCLES shortened to 4 clocks per millisecond.
`timescale 1ns/1ps

module cvp_top_tb
    import cvp_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] v; logic e;} cvp_row_t;

    logic        ref_clk_in   = 1'b0;
    logic        rst_n_in     = 1'b0;
    cvp_sample_t sample_in    = '0;
    logic        psel_in      = 1'b0;
    logic        penable_in   = 1'b0;
    logic        pwrite_in    = 1'b0;
    logic [7:0]  paddr_in     = 8'h00;
    logic [31:0] pwdata_in    = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    cvp_flags_t  flags_out;
    logic [31:0] rd_data;
    logic        rd_err;
    int          failures     = 0;
    int          total_checks = 0;
    // Reads give value, writes give data; e is the expected error
    cvp_row_t    rows [0:21]  = '{
        '{1'b0, 8'h00, 32'he80, 1'b0}, '{1'b0, 8'h04, 32'h600, 1'b0}, '{1'b0, 8'h08, 32'he2a, 1'b0},
        '{1'b0, 8'h0c, 32'hdd5, 1'b0}, '{1'b0, 8'h10, 32'h201, 1'b0}, '{1'b0, 8'h14, 32'h900, 1'b0},
        '{1'b0, 8'h18, 32'ha00, 1'b0}, '{1'b0, 8'h1c, 32'h201, 1'b0}, '{1'b0, 8'h20, 32'h6aa, 1'b0},
        '{1'b0, 8'h24, 32'h201, 1'b0}, '{1'b0, 8'h28, 32'h7aa, 1'b0}, '{1'b0, 8'h2c, 32'h0, 1'b0},
        '{1'b1, 8'h10, 32'hffffffff, 1'b0}, '{1'b0, 8'h10, 32'h7ff, 1'b0}, '{1'b1, 8'h10, 32'h2, 1'b0},
        '{1'b1, 8'h1c, 32'h0, 1'b0}, '{1'b1, 8'h24, 32'h0, 1'b0}, '{1'b0, 8'h30, 32'h0, 1'b1},
        '{1'b1, 8'h31, 32'h5, 1'b1}, '{1'b0, 8'h1d, 32'h0, 1'b1}, '{1'b1, 8'h2c, 32'h3f, 1'b0},
        '{1'b0, 8'h2c, 32'h0, 1'b0}};

    cvp_top #(.MS_CYCLES(4)) u_cvp_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sample_in(sample_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .flags_out(flags_out));

    task report_and_stop;
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x)
        begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, g, x);
        end
    endtask

    // Entered just after a rising edge; returns one idle cycle after completion
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 20);
        chk({31'h0, pready_out}, 32'h1);
        rd_data = prdata_out;
        rd_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    // One scan of two cells, then a gap cycle
    task scan(input logic [11:0] c0, input logic [11:0] c1);
        sample_in <= '{1'b1, 1'b0, c0};
        @(posedge ref_clk_in);
        sample_in <= '{1'b1, 1'b1, c1};
        @(posedge ref_clk_in);
        sample_in <= '0;
        @(posedge ref_clk_in);
    endtask

    task flag(input int i, input logic x);
        repeat (2) @(negedge ref_clk_in);
        chk({31'h0, flags_out[i]}, {31'h0, x});
        @(posedge ref_clk_in);
    endtask

    initial
    begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        #(50 * 40000);
        failures++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk_in);
        chk({26'h0, flags_out}, 32'h0);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].v);
            if (!rows[i].w)
                chk(rd_data, rows[i].v);
            chk({31'h0, rd_err}, {31'h0, rows[i].e});
        end
        repeat (4) scan(12'hd00, 12'he81);
        flag(5, 1'b0);
        scan(12'he81, 12'hd00);
        flag(5, 1'b1);
        scan(12'hdd4, 12'hdd5);
        flag(5, 1'b1);
        scan(12'hdd4, 12'hdd4);
        flag(5, 1'b0);
        repeat (10) scan(12'hdd4, 12'hdd4);
        apb(1'b1, 8'h10, 32'h202);
        repeat (1300) scan(12'he2b, 12'hd00);
        flag(3, 1'b0);
        repeat (1400) scan(12'he2b, 12'hd00);
        flag(3, 1'b1);
        apb(1'b1, 8'h10, 32'h2);
        repeat (10) scan(12'hdd5, 12'hdd4);
        flag(3, 1'b1);
        repeat (10) scan(12'hdd4, 12'hdd4);
        flag(3, 1'b0);
        repeat (4) scan(12'h5ff, 12'ha01);
        scan(12'ha01, 12'ha01);
        repeat (4) scan(12'ha01, 12'h5ff);
        flag(4, 1'b0);
        scan(12'h5ff, 12'ha01);
        flag(4, 1'b1);
        scan(12'ha00, 12'ha01);
        flag(4, 1'b1);
        scan(12'ha01, 12'ha01);
        flag(4, 1'b0);
        scan(12'h8ff, 12'ha01);
        flag(2, 1'b1);
        repeat (3900) scan(12'ha01, 12'ha01);
        flag(2, 1'b1);
        repeat (300) scan(12'ha01, 12'ha01);
        flag(2, 1'b0);
        scan(12'h7a9, 12'ha01);
        flag(0, 1'b1);
        flag(2, 1'b1);
        scan(12'h80e, 12'ha01);
        flag(0, 1'b1);
        scan(12'h80f, 12'h80f);
        flag(0, 1'b0);
        scan(12'h6a9, 12'ha01);
        flag(1, 1'b1);
        scan(12'h6aa, 12'ha01);
        flag(1, 1'b0);
        rst_n_in <= 1'b0;
        @(posedge ref_clk_in);
        chk({26'h0, flags_out}, 32'h0);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd_data, 32'h201);
        apb(1'b0, 8'h24, 32'h0);
        chk(rd_data, 32'h201);
        report_and_stop();
    end
endmodule // cvp_top_tb
